/* rtl/epd_link_pkg.sv */
// Constants, timing counts and state types shared by both ends of the
// serial write port. Assumes a 200 MHz system clock at each end.
`default_nettype none

package epd_link_pkg;

  localparam int CLK_PERIOD_NS = 5;

  // Least link timings in ns
  localparam int SCLK_CYCLE_MIN_NS = 250;
  localparam int SCLK_HIGH_MIN_NS  = 100;
  localparam int ADDR_SETUP_MIN_NS = 150;
  localparam int ADDR_HOLD_MIN_NS  = 150;
  localparam int CS_SETUP_MIN_NS   = 120;

  // Least time rounds up, never below one cycle
  function automatic int cycles_at_least(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int HALF_CYCLES  = cycles_at_least(SCLK_CYCLE_MIN_NS / 2) >
                                cycles_at_least(SCLK_HIGH_MIN_NS) ?
                                cycles_at_least(SCLK_CYCLE_MIN_NS / 2) :
                                cycles_at_least(SCLK_HIGH_MIN_NS);
  localparam int SETUP_CYCLES = cycles_at_least(ADDR_SETUP_MIN_NS) >
                                cycles_at_least(CS_SETUP_MIN_NS) ?
                                cycles_at_least(ADDR_SETUP_MIN_NS) :
                                cycles_at_least(CS_SETUP_MIN_NS);
  localparam int HOLD_CYCLES  = cycles_at_least(ADDR_HOLD_MIN_NS);

  localparam int TIMER_W = 6;
  localparam logic [TIMER_W-1:0] HALF_TICKS  = TIMER_W'(HALF_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SETUP_TICKS = TIMER_W'(SETUP_CYCLES - 1);
  localparam logic [TIMER_W-1:0] HOLD_TICKS  = TIMER_W'(HOLD_CYCLES - 1);

  // Framing
  localparam int BYTE_W = 8;
  localparam int WORD_W = BYTE_W + 1;
  localparam logic [3:0] BITS_FOUR_WIRE  = 4'h8;
  localparam logic [3:0] BITS_THREE_WIRE = 4'h9;
  localparam logic [3:0] PRIME_EDGES     = 4'h4;
  localparam logic       KIND_COMMAND    = 1'h0;
  localparam logic       KIND_DATA       = 1'h1;
  localparam logic       STRAP_FOUR_WIRE = 1'h0;
  localparam logic       STRAP_THREE_WIRE = 1'h1;

  localparam int FIFO_DEPTH = 4;

  typedef enum {
    HOST_PRIME, HOST_IDLE, HOST_SETUP, HOST_HIGH, HOST_LOW, HOST_HOLD, HOST_GAP
  } host_state_type;

endpackage

`default_nettype wire

/* rtl/epd_link_if.sv */
// Pins between the host controller and the display module serial port.
// Every pin is driven by exactly one end; no two-way pins are used.
`timescale 1ns/10ps
`default_nettype none

interface epd_link_if;
  logic sclk;
  logic serial_data_in;
  logic byte_kind;
  logic chip_sel_n;
  logic bus_mode_strap;
  logic module_reset_n;
  logic panel_active_flag_n;

  modport device (
    input  sclk,
    input  serial_data_in,
    input  byte_kind,
    input  chip_sel_n,
    input  bus_mode_strap,
    input  module_reset_n,
    output panel_active_flag_n
  );

  modport host (
    output sclk,
    output serial_data_in,
    output byte_kind,
    output chip_sel_n,
    output bus_mode_strap,
    output module_reset_n,
    input  panel_active_flag_n
  );
endinterface

`default_nettype wire

/* rtl/epd_device_end.sv */
// Display module end of the serial write port, plus the small FIFO that
// the host end uses. Link logic runs on the host-made serial clock; the
// write strobes run on the local system clock.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module sync_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // System
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] ONE_COUNT  = CNT_W'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;
  logic             push;
  logic             pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + ONE_COUNT;
    end else if (pop && !push) begin
      next_count = count - ONE_COUNT;
    end
  end

  // Flags are registered from the next count so both sides see flop outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= (next_count != FULL_COUNT);
      out_valid <= (next_count != '0);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr];
endmodule

////////////////////////////////////////////////////////////////////////////////

module epd_device_end
  import epd_link_pkg::*;
(
  // System
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Link
  epd_link_if.device             link,
  // Panel core side
  input  wire logic              panel_busy,
  output logic                   cmd_write,
  output logic                   ram_write,
  output logic      [BYTE_W-1:0] write_byte
);
  // Internal resets; the module reset pin acts like the system reset
  logic core_rst_n;
  logic frame_rst_n;

  assign core_rst_n  = rst_n && link.module_reset_n;
  assign frame_rst_n = core_rst_n && !link.chip_sel_n;

  //////////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by the serial clock pin

  logic              strap_meta;
  logic              strap_sync;
  logic [3:0]        bit_cnt;
  logic [BYTE_W-1:0] shift;
  logic [3:0]        next_bit_cnt;
  logic [BYTE_W-1:0] next_shift;
  logic [WORD_W-1:0] word;
  logic              word_toggle;
  logic [WORD_W-1:0] next_word;
  logic              next_word_toggle;
  logic [3:0]        frame_bits;
  logic [BYTE_W-1:0] full_byte;
  logic              word_done;

  // Strap is caught on the link clock; the host gives a few idle clocks
  // with select high after reset so this settles before the first frame
  always_ff @(posedge link.sclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      strap_meta <= STRAP_FOUR_WIRE;
      strap_sync <= STRAP_FOUR_WIRE;
    end else begin
      strap_meta <= link.bus_mode_strap;
      strap_sync <= strap_meta;
    end
  end

  always_comb begin
    frame_bits       = (strap_sync == STRAP_THREE_WIRE) ?
                       BITS_THREE_WIRE : BITS_FOUR_WIRE;
    full_byte        = {shift[BYTE_W-2:0], link.serial_data_in};
    word_done        = (bit_cnt == frame_bits - 4'h1);
    next_shift       = full_byte;
    next_bit_cnt     = word_done ? 4'h0 : bit_cnt + 4'h1;
    next_word        = word;
    next_word_toggle = word_toggle;
    if (word_done) begin
      next_word_toggle = !word_toggle;
      if (strap_sync == STRAP_THREE_WIRE) begin
        // Kind pin is ignored here; the first bit of the nine chose it
        next_word = {shift[BYTE_W-1], full_byte};
      end else begin
        next_word = {link.byte_kind, full_byte};
      end
    end
  end

  // Bit counter and partial byte are cleared whenever select is high
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 4'h0;
      shift   <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
    end
  end

  // The finished word survives the frame so the system side can read it
  always_ff @(posedge link.sclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      word        <= '0;
      word_toggle <= 1'b0;
    end else begin
      word        <= next_word;
      word_toggle <= next_word_toggle;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain: toggle crossing and write strobes

  logic              toggle_meta;
  logic              toggle_sync;
  logic              toggle_seen;
  logic              busy_flag_n;
  logic              next_cmd_write;
  logic              next_ram_write;
  logic [BYTE_W-1:0] next_write_byte;
  logic              new_word;

  // Word is stable for at least seven link clocks after its toggle, far
  // longer than the three system clocks the crossing needs
  always_comb begin
    new_word        = (toggle_sync != toggle_seen);
    next_cmd_write  = new_word && (word[BYTE_W] == KIND_COMMAND);
    next_ram_write  = new_word && (word[BYTE_W] == KIND_DATA);
    next_write_byte = new_word ? word[BYTE_W-1:0] : write_byte;
  end

  always_ff @(posedge clock or negedge core_rst_n) begin
    if (!core_rst_n) begin
      toggle_meta <= 1'b0;
      toggle_sync <= 1'b0;
      toggle_seen <= 1'b0;
      cmd_write   <= 1'b0;
      ram_write   <= 1'b0;
      write_byte  <= '0;
      busy_flag_n <= 1'b1;
    end else begin
      toggle_meta <= word_toggle;
      toggle_sync <= toggle_meta;
      toggle_seen <= toggle_sync;
      cmd_write   <= next_cmd_write;
      ram_write   <= next_ram_write;
      write_byte  <= next_write_byte;
      busy_flag_n <= !panel_busy;
    end
  end

  // Only the busy flag goes back; no read data path exists
  assign link.panel_active_flag_n = busy_flag_n;
endmodule

`default_nettype wire

/* rtl/epd_host_end.sv */
// Host controller end of the serial write port. Bytes queue in a FIFO
// and are sent one per select frame; the serial clock is divided from
// the 200 MHz system clock. Assumes the device end sits on the far side.
`timescale 1ns/10ps
`default_nettype none

module epd_host_end
  import epd_link_pkg::*;
(
  // System
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Link
  epd_link_if.host               link,
  // Mode and panel reset
  input  wire logic              three_wire,
  input  wire logic              panel_reset,
  // Byte stream
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic              in_is_data,
  input  wire logic [BYTE_W-1:0] in_byte
);
  host_state_type    state;
  host_state_type    next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic [3:0]        bits_left;
  logic [3:0]        next_bits_left;
  logic [WORD_W-1:0] shift;
  logic [WORD_W-1:0] next_shift;
  logic              sclk;
  logic              next_sclk;
  logic              cs_n;
  logic              next_cs_n;
  logic              sdo;
  logic              next_sdo;
  logic              kind;
  logic              next_kind;
  logic              strap;
  logic              next_strap;
  logic              mod_rst_n;
  logic              busy_meta;
  logic              busy_sync;
  logic              q_valid;
  logic              q_ready;
  logic [WORD_W-1:0] q_data;
  logic              expired;

  sync_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) queue (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_is_data, in_byte}),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    expired        = (timer == '0);
    next_state     = state;
    next_timer     = expired ? timer : timer - TIMER_W'(1);
    next_bits_left = bits_left;
    next_shift     = shift;
    next_sclk      = sclk;
    next_cs_n      = cs_n;
    next_sdo       = sdo;
    next_kind      = kind;
    next_strap     = strap;
    // Commands wait while the panel reports busy; data may still flow
    q_ready        = (state == HOST_IDLE) && q_valid &&
                     (q_data[BYTE_W] == KIND_DATA || busy_sync);
    case (state)
      HOST_PRIME: begin
        // Strap taken after reset; idle clocks let the far end settle
        next_strap = three_wire ? STRAP_THREE_WIRE : STRAP_FOUR_WIRE;
        if (expired) begin
          next_sclk      = !sclk;
          next_timer     = HALF_TICKS;
          next_bits_left = bits_left - 4'h1;
          if (bits_left == 4'h1) begin
            next_state = HOST_IDLE;
          end
        end
      end
      HOST_IDLE: begin
        if (q_ready) begin
          next_cs_n  = 1'b0;
          next_timer = SETUP_TICKS;
          next_state = HOST_SETUP;
          if (strap == STRAP_THREE_WIRE) begin
            next_shift     = q_data;
            next_kind      = 1'b0;
            next_bits_left = BITS_THREE_WIRE;
          end else begin
            next_shift     = {q_data[BYTE_W-1:0], 1'b0};
            next_kind      = q_data[BYTE_W];
            next_bits_left = BITS_FOUR_WIRE;
          end
          next_sdo = next_shift[WORD_W-1];
        end
      end
      HOST_SETUP, HOST_LOW: begin
        if (expired) begin
          next_sclk  = 1'b1;
          next_timer = HALF_TICKS;
          next_state = HOST_HIGH;
        end
      end
      HOST_HIGH: begin
        if (expired) begin
          next_sclk      = 1'b0;
          next_bits_left = bits_left - 4'h1;
          if (bits_left == 4'h1) begin
            next_timer = HOLD_TICKS;
            next_state = HOST_HOLD;
          end else begin
            next_shift = {shift[WORD_W-2:0], 1'b0};
            next_sdo   = shift[WORD_W-2];
            next_timer = HALF_TICKS;
            next_state = HOST_LOW;
          end
        end
      end
      HOST_HOLD: begin
        if (expired) begin
          next_cs_n  = 1'b1;
          next_timer = HALF_TICKS;
          next_state = HOST_GAP;
        end
      end
      HOST_GAP: begin
        if (expired) begin
          next_kind  = 1'b0;
          next_state = HOST_IDLE;
        end
      end
      default: begin
        next_state = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state     <= HOST_PRIME;
      timer     <= HALF_TICKS;
      bits_left <= PRIME_EDGES;
      shift     <= '0;
      sclk      <= 1'b0;
      cs_n      <= 1'b1;
      sdo       <= 1'b0;
      kind      <= 1'b0;
      strap     <= STRAP_FOUR_WIRE;
      mod_rst_n <= 1'b0;
      busy_meta <= 1'b1;
      busy_sync <= 1'b1;
    end else begin
      state     <= next_state;
      timer     <= next_timer;
      bits_left <= next_bits_left;
      shift     <= next_shift;
      sclk      <= next_sclk;
      cs_n      <= next_cs_n;
      sdo       <= next_sdo;
      kind      <= next_kind;
      strap     <= next_strap;
      mod_rst_n <= !panel_reset;
      busy_meta <= link.panel_active_flag_n;
      busy_sync <= busy_meta;
    end
  end

  // Write-only: the host never samples the data pin
  assign link.sclk           = sclk;
  assign link.serial_data_in = sdo;
  assign link.byte_kind      = kind;
  assign link.chip_sel_n     = cs_n;
  assign link.bus_mode_strap = strap;
  assign link.module_reset_n = mod_rst_n;
endmodule

`default_nettype wire

/* sim/epd_link_assertions.sv */
// Assertions on the serial link pins between the host and device ends.
// Assumes every pin but the busy flag is a host flop on the host clock.
`timescale 1ns/10ps
`default_nettype none

module epd_link_assertions
  import epd_link_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Link
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic byte_kind,
  input wire logic chip_sel_n,
  input wire logic bus_mode_strap,
  input wire logic module_reset_n,
  input wire logic panel_active_flag_n
);
  logic [5:0] hi_cnt;
  logic [5:0] lo_cnt;
  logic [5:0] next_hi_cnt;
  logic [5:0] next_lo_cnt;
  logic [3:0] rise_cnt;
  logic [3:0] next_rise_cnt;
  logic       sclk_q;

  //////////////////////////////////////////////////////////////////////////////
  // Low count saturates so long idle spells cannot wrap onto the hold figure
  always_comb begin
    next_hi_cnt = sclk ? hi_cnt + 6'h01 : 6'h00;
    next_lo_cnt = sclk ? 6'h00 : lo_cnt + {5'h00, lo_cnt != 6'h3f};
    next_rise_cnt = chip_sel_n ? 4'h0 : rise_cnt + {3'h0, sclk & ~sclk_q};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 6'h00;
      lo_cnt <= 6'h00;
      rise_cnt <= 4'h0;
      sclk_q <= 1'b0;
    end else begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
      rise_cnt <= next_rise_cnt;
      sclk_q <= sclk;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  high_time_a: assert property ($fell(sclk) |-> hi_cnt == 6'(HALF_CYCLES))
    else $error("serial clock high time wrong");
  select_setup_a: assert property ($fell(chip_sel_n) |-> !sclk[*8] ##23 $rose(sclk))
    else $error("select setup before first clock wrong");
  select_hold_a: assert property ($rose(chip_sel_n) |-> lo_cnt == 6'(HOLD_CYCLES))
    else $error("select hold after last clock wrong");
  frame_gap_a: assert property ($rose(chip_sel_n) |-> (chip_sel_n && !sclk)[*8])
    else $error("clock or select moved in frame gap");
  bit_count_a: assert property ($rose(chip_sel_n) |->
    rise_cnt == (bus_mode_strap ? BITS_THREE_WIRE : BITS_FOUR_WIRE))
    else $error("clock count in frame wrong");
  data_stable_a: assert property (!chip_sel_n && sclk && $past(sclk)
    |-> $stable(serial_data_in))
    else $error("serial data moved while clock high");
  kind_tied_a: assert property (bus_mode_strap |-> !byte_kind)
    else $error("kind pin not held low in three wire mode");
  reset_quiet_a: assert property (!module_reset_n && !$past(module_reset_n)
    |-> panel_active_flag_n)
    else $error("busy flag low during panel reset");

  four_wire_c: cover property ($rose(chip_sel_n) && !bus_mode_strap);
  three_wire_c: cover property ($rose(chip_sel_n) && bus_mode_strap);
  busy_c: cover property ($fell(panel_active_flag_n));
endmodule

`default_nettype wire

/* sim/tb_epd_serial_write_port.sv */
// Testbench: host end and device end joined by one link; a second device
// end sits on a link driven by the bench to break framing on purpose.
`timescale 1ns/10ps
`default_nettype none

module tb_epd_serial_write_port
  import epd_link_pkg::*;
;
  logic              clock, dev_clock, rst_n, three_wire, panel_reset;
  logic              in_valid, in_ready, in_is_data, panel_busy, saw_full;
  logic [BYTE_W-1:0] in_byte, write_byte, write_byte_b;
  logic              cmd_write, ram_write, cmd_write_b, ram_write_b, wire_kind;
  logic [8:0]        wire_word, exp_w, w;
  logic [8:0]        exp_q[$];
  logic [8:0]        exp_b[$];
  int                num_errors, total_checks, seed, n;

  epd_link_if link ();
  epd_link_if link_b ();
  epd_host_end u_epd_host_end (.clock(clock), .rst_n(rst_n), .link(link.host),
    .three_wire(three_wire), .panel_reset(panel_reset), .in_valid(in_valid),
    .in_ready(in_ready), .in_is_data(in_is_data), .in_byte(in_byte));
  epd_device_end u_epd_device_end (.clock(dev_clock), .rst_n(rst_n), .link(link.device),
    .panel_busy(panel_busy), .cmd_write(cmd_write), .ram_write(ram_write),
    .write_byte(write_byte));
  epd_device_end u_epd_device_end_b (.clock(clock), .rst_n(rst_n), .link(link_b.device),
    .panel_busy(1'b0), .cmd_write(cmd_write_b), .ram_write(ram_write_b),
    .write_byte(write_byte_b));
  epd_link_assertions u_epd_link_assertions (.clock(clock), .rst_n(rst_n),
    .sclk(link.sclk), .serial_data_in(link.serial_data_in), .byte_kind(link.byte_kind),
    .chip_sel_n(link.chip_sel_n), .bus_mode_strap(link.bus_mode_strap),
    .module_reset_n(link.module_reset_n), .panel_active_flag_n(link.panel_active_flag_n));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Device end runs off its own clock, same period as the host's but 1.3 ns behind it
  initial begin
    dev_clock = 1'b0;
    #1.3;
    forever #2.5 dev_clock = ~dev_clock;
  end

  task automatic check_word(input string what, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    check_word(what, {8'h00, exp}, {8'h00, got});
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bytes are queued as expected only at the edge the host takes them
  task automatic push(input logic kind, input logic [BYTE_W-1:0] b);
    int t;
    t = 0;
    in_valid <= 1'b1;
    in_is_data <= kind;
    in_byte <= b;
    @(posedge clock);
    while (in_ready !== 1'b1 && t < 5000) begin
      saw_full <= 1'b1;
      t++;
      @(posedge clock);
    end
    check_flag("push_taken", 1'b1, in_ready === 1'b1);
    exp_q.push_back({kind, b});
  endtask

  task automatic drain();
    int t;
    t = 0;
    while ((exp_q.size() != 0 || exp_b.size() != 0) && t < 20000) begin
      @(posedge clock);
      t++;
    end
    check_flag("drained", 1'b1, exp_q.size() == 0 && exp_b.size() == 0);
  endtask

  // Bench-driven frame on the second link: kind pin from w[8], bits MSB first
  task automatic frame_b(input logic [8:0] w, input int nbits);
    link_b.chip_sel_n <= 1'b0;
    link_b.byte_kind <= w[8];
    repeat (30) @(posedge clock);
    for (int i = nbits - 1; i >= 0; i--) begin
      // Bench link clock: 125 ns period, 12 low and 13 high system clocks
      link_b.serial_data_in <= w[i];
      repeat (12) @(posedge clock);
      link_b.sclk <= 1'b1;
      repeat (13) @(posedge clock);
      link_b.sclk <= 1'b0;
    end
    repeat (30) @(posedge clock);
    link_b.chip_sel_n <= 1'b1;
    link_b.serial_data_in <= ~w[0];
    repeat (25) @(posedge clock);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge link.sclk) begin
    if (!link.chip_sel_n) begin
      wire_word <= {wire_word[7:0], link.serial_data_in};
      wire_kind <= link.byte_kind;
    end
  end

  // An empty queue yields an unknown expectation, so a stray write mismatches
  always @(posedge dev_clock) begin
    if (cmd_write === 1'b1 || ram_write === 1'b1) begin
      exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 9'hxxx;
      check_word("device_write", exp_w, {ram_write, write_byte});
      check_word("wire_word", three_wire ? exp_w : {1'b0, exp_w[7:0]},
        three_wire ? wire_word : {1'b0, wire_word[7:0]});
      check_flag("kind_pin", three_wire ? 1'b0 : exp_w[8], wire_kind);
    end
  end

  always @(posedge clock) begin
    if (cmd_write_b === 1'b1 || ram_write_b === 1'b1)
      check_word("far_write", (exp_b.size() != 0) ? exp_b.pop_front() : 9'hxxx,
        {ram_write_b, write_byte_b});
  end

  initial begin
    #400000;
    num_errors++;
    $display("Error watchdog expected done seen hang");
    finish_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h016c;
    {num_errors, total_checks} = '0;
    {rst_n, three_wire, panel_reset, in_valid, in_is_data, panel_busy, saw_full} = '0;
    in_byte = 8'h00;
    {link_b.sclk, link_b.serial_data_in, link_b.byte_kind, link_b.bus_mode_strap} = '0;
    {link_b.chip_sel_n, link_b.module_reset_n} = 2'h3;
    for (int m = 0; m < 2; m++) begin
      rst_n <= 1'b0;
      three_wire <= m[0];
      saw_full <= 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      push(1'b0, 8'h00);
      push(1'b1, 8'hff);
      for (n = 0; n < 8; n++)
        push(1'($random(seed)), 8'($random(seed)));
      in_valid <= 1'b0;
      drain();
      check_flag("fifo_full", 1'b1, saw_full);
      if (m == 0) begin
        panel_busy <= 1'b1;
        repeat (10) @(posedge clock);
        check_flag("busy_flag", 1'b0, link.panel_active_flag_n);
        push(1'b1, 8'h3c);
        push(1'b0, 8'ha5);
        in_valid <= 1'b0;
        repeat (1500) @(posedge clock);
        check_flag("cmd_held", 1'b1, exp_q.size() == 1);
        panel_busy <= 1'b0;
        drain();
        check_flag("busy_flag", 1'b1, link.panel_active_flag_n);
        panel_reset <= 1'b1;
        panel_busy <= 1'b1;
        repeat (8) @(posedge clock);
        check_flag("reset_pin", 1'b0, link.module_reset_n);
        check_flag("flag_in_reset", 1'b1, link.panel_active_flag_n);
        {panel_reset, panel_busy} <= 2'h0;
        repeat (8) @(posedge clock);
        push(1'b1, 8'h5a);
        in_valid <= 1'b0;
        drain();
      end
      $display("test stream mode %0d done", m);
    end
    // Clock edges with select high must be ignored; they also feed strap sync
    for (n = 0; n < 9; n++) begin
      link_b.serial_data_in <= n[0];
      link_b.sclk <= 1'b1;
      repeat (13) @(posedge clock);
      link_b.sclk <= 1'b0;
      repeat (12) @(posedge clock);
    end
    w = {1'b1, 8'($random(seed))};
    frame_b(w, 5);
    exp_b.push_back(w);
    frame_b(w, 8);
    w = {1'b0, 8'($random(seed))};
    exp_b.push_back(w);
    frame_b(w, 8);
    drain();
    $display("test abort and select done");
    finish_test();
  end
endmodule

`default_nettype wire
